// file: design/smm_hole_pkg.sv
// Constants, field layout and carrier types for the SMM RAM and 15 MB hole decode.
// Assumes one system clock and configuration writes from the host bridge.
// Behaviour
// - Hole enable set stops main-memory claims from 15 MB up to 16 MB.
// - Memory behind the hole is never relocated; it just becomes unreachable.
// - Open and closed controls act only while global SMM enable is one; lock freezes its fields whatever global enable is.
// - Open set and lock clear makes SMM RAM visible without SMM decode.
// - Closed set denies data references to SMM RAM, even in SMM.
// - Closed set still lets code references reach SMM RAM.
// - Closed control touches only the compatible SMM range, nothing else.
// - Lock forces open to zero and freezes the lockable fields.
// - Lock is set by a normal write and cleared only by reset.
// - Global enable maps 128 KB of memory at A0000h for SMM accesses.
// - Extended SMM functions stay disabled unless global enable is one.
// - Base segment field is fixed at 010 and ignores writes.
// - No translation; unmet access conditions forward to the hub interface.
package smm_hole_pkg;

   // -------------------------------------------------------------
   // Configuration space
   // -------------------------------------------------------------
   localparam int unsigned CFG_W      = 8;
   localparam logic [7:0]  HOLE_OFS   = 8'h97;
   localparam logic [7:0]  SMM_OFS    = 8'h9d;
   localparam logic [7:0]  HOLE_RST   = 8'h00;
   localparam logic [7:0]  SMM_RST    = 8'h02;
   localparam logic [7:0]  RD_NONE    = 8'h00;
   localparam int unsigned HOLE_EN_B  = 7;
   localparam int unsigned OPEN_B     = 6;
   localparam int unsigned BLOCK_B    = 5;
   localparam int unsigned LOCK_B     = 4;
   localparam int unsigned GEN_B      = 3;
   localparam int unsigned BASE_W     = 3;
   localparam logic [2:0]  BASE_FIXED = 3'h2;

   // -------------------------------------------------------------
   // Host address map
   // -------------------------------------------------------------
   localparam int unsigned ADDR_W    = 32;
   localparam logic [31:0] HOLE_LO   = 32'h00f0_0000;
   localparam logic [31:0] HOLE_HI   = 32'h0100_0000;
   localparam logic [31:0] COMPAT_LO = 32'h000a_0000;
   localparam logic [31:0] COMPAT_HI = 32'h000c_0000;

   // Host request as seen at the address strobe
   typedef struct packed {
      logic [31:0] addr;
      logic        smm;
      logic        code;
   } host_req_s;

   // Routing answer for one host request
   typedef struct packed {
      logic        dram;
      logic        hub;
      logic [31:0] addr;
   } route_s;

   // Live SMM controls fed to the decoder
   typedef struct packed {
      logic hole_en;
      logic open;
      logic block;
      logic lock;
      logic gen;
   } ctrl_s;

endpackage

// file: design/smm_ram_and_dram_hole_decode.sv
// SMM RAM control and fixed 15 MB hole: registers plus host routing.
// Assumes host strobes and configuration strobes are on the system clock.
module smm_ram_and_dram_hole_decode (
   input  wire logic                   I_CLK,
   input  wire logic                   I_RST,
   input  wire logic                   I_CFG_WR,
   input  wire logic                   I_CFG_RD,
   input  wire logic [7:0]             I_CFG_ADDR,
   input  wire logic [7:0]             I_CFG_WDATA,
   input  wire logic                   I_HOST_ADDR_STROBE,
   input  smm_hole_pkg::host_req_s     I_HOST_REQ,
   output logic [7:0]                  O_CFG_RDATA,
   output logic                        O_CFG_RVALID,
   output logic                        O_ROUTE_VALID,
   output smm_hole_pkg::route_s        O_ROUTE,
   output logic                        O_SMM_LOCK,
   output logic                        O_EXT_SMM_ENABLE
);

   // -------------------------------------------------------------
   // Register state
   // -------------------------------------------------------------
   logic                 gap_15m_enable_reg;
   logic                 smm_open_reg;
   logic                 smm_data_block_reg;
   logic                 smm_lockdown_reg;
   logic                 global_smm_ram_enable_reg;
   logic [7:0]           rdata_reg;
   logic                 rvalid_reg;
   logic                 route_valid_reg;
   smm_hole_pkg::route_s route_reg;
   logic                 ext_en_reg;

   logic                 wr_hole;
   logic                 wr_smm;
   logic [7:0]           hole_view;
   logic [7:0]           smm_view;
   smm_hole_pkg::ctrl_s  ctrl;
   smm_hole_pkg::route_s route_next;

   // Write decode
   assign wr_hole = I_CFG_WR && (I_CFG_ADDR == smm_hole_pkg::HOLE_OFS);
   assign wr_smm  = I_CFG_WR && (I_CFG_ADDR == smm_hole_pkg::SMM_OFS);

   // -------------------------------------------------------------
   // Hole control register
   // -------------------------------------------------------------
   // Only the enable bit is stored
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         gap_15m_enable_reg <= smm_hole_pkg::HOLE_RST[smm_hole_pkg::HOLE_EN_B];
      end else if (wr_hole) begin
         gap_15m_enable_reg <= I_CFG_WDATA[smm_hole_pkg::HOLE_EN_B];
      end
   end

   // -------------------------------------------------------------
   // SMM RAM control register
   // -------------------------------------------------------------
   // Lock bit: set by a write, cleared only by reset
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         smm_lockdown_reg <= smm_hole_pkg::SMM_RST[smm_hole_pkg::LOCK_B];
      end else if (wr_smm && I_CFG_WDATA[smm_hole_pkg::LOCK_B]) begin
         smm_lockdown_reg <= 1'b1;
      end
   end

   // Open bit: frozen under lock, cleared when lock is set
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         smm_open_reg <= smm_hole_pkg::SMM_RST[smm_hole_pkg::OPEN_B];
      end else if (wr_smm && !smm_lockdown_reg) begin
         if (I_CFG_WDATA[smm_hole_pkg::LOCK_B]) begin
            smm_open_reg <= 1'b0;
         end else begin
            smm_open_reg <= I_CFG_WDATA[smm_hole_pkg::OPEN_B];
         end
      end
   end

   // Closed bit stays writable even under lock
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         smm_data_block_reg <= smm_hole_pkg::SMM_RST[smm_hole_pkg::BLOCK_B];
      end else if (wr_smm) begin
         smm_data_block_reg <= I_CFG_WDATA[smm_hole_pkg::BLOCK_B];
      end
   end

   // Global enable: frozen under lock
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         global_smm_ram_enable_reg <= smm_hole_pkg::SMM_RST[smm_hole_pkg::GEN_B];
      end else if (wr_smm && !smm_lockdown_reg) begin
         global_smm_ram_enable_reg <= I_CFG_WDATA[smm_hole_pkg::GEN_B];
      end
   end

   // -------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------
   // Read views; reserved bits zero, base segment fixed
   always_comb begin
      hole_view = smm_hole_pkg::RD_NONE;
      hole_view[smm_hole_pkg::HOLE_EN_B] = gap_15m_enable_reg;
      smm_view = smm_hole_pkg::RD_NONE;
      smm_view[smm_hole_pkg::OPEN_B]  = smm_open_reg;
      smm_view[smm_hole_pkg::BLOCK_B] = smm_data_block_reg;
      smm_view[smm_hole_pkg::LOCK_B]  = smm_lockdown_reg;
      smm_view[smm_hole_pkg::GEN_B]   = global_smm_ram_enable_reg;
      smm_view[smm_hole_pkg::BASE_W-1:0] = smm_hole_pkg::BASE_FIXED;
   end

   // Registered read data, unmapped offsets read zero
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         rdata_reg  <= smm_hole_pkg::RD_NONE;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= I_CFG_RD;
         if (!I_CFG_RD) begin
            rdata_reg <= smm_hole_pkg::RD_NONE;
         end else if (I_CFG_ADDR == smm_hole_pkg::HOLE_OFS) begin
            rdata_reg <= hole_view;
         end else if (I_CFG_ADDR == smm_hole_pkg::SMM_OFS) begin
            rdata_reg <= smm_view;
         end else begin
            rdata_reg <= smm_hole_pkg::RD_NONE;
         end
      end
   end

   // -------------------------------------------------------------
   // Host routing
   // -------------------------------------------------------------
   // Live controls for the decoder
   always_comb begin
      ctrl.hole_en = gap_15m_enable_reg;
      ctrl.open    = smm_open_reg;
      ctrl.block   = smm_data_block_reg;
      ctrl.lock    = smm_lockdown_reg;
      ctrl.gen     = global_smm_ram_enable_reg;
   end

   smm_route_decode u_decode (
      .i_valid (I_HOST_ADDR_STROBE),
      .i_req   (I_HOST_REQ),
      .i_ctrl  (ctrl),
      .o_route (route_next)
   );

   // One-cycle routing answer per strobe
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         route_valid_reg <= 1'b0;
         route_reg       <= '0;
      end else begin
         route_valid_reg <= I_HOST_ADDR_STROBE;
         route_reg       <= route_next;
      end
   end

   // Extended SMM permission to the neighbouring register
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         ext_en_reg <= 1'b0;
      end else begin
         ext_en_reg <= global_smm_ram_enable_reg;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign O_CFG_RDATA      = rdata_reg;
   assign O_CFG_RVALID     = rvalid_reg;
   assign O_ROUTE_VALID    = route_valid_reg;
   assign O_ROUTE          = route_reg;
   assign O_SMM_LOCK       = smm_lockdown_reg;
   assign O_EXT_SMM_ENABLE = ext_en_reg;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);

   logic req_hole;
   logic req_compat;
   assign req_hole   = (I_HOST_REQ.addr >= smm_hole_pkg::HOLE_LO)
                       && (I_HOST_REQ.addr < smm_hole_pkg::HOLE_HI);
   assign req_compat = (I_HOST_REQ.addr >= smm_hole_pkg::COMPAT_LO)
                       && (I_HOST_REQ.addr < smm_hole_pkg::COMPAT_HI);

   hole_blocks_a: assert property (
      I_HOST_ADDR_STROBE && req_hole && gap_15m_enable_reg
      |=> O_ROUTE_VALID && !O_ROUTE.dram && O_ROUTE.hub)
      else $error("hole access claimed for memory");

   hole_off_a: assert property (
      I_HOST_ADDR_STROBE && req_hole && !gap_15m_enable_reg |=> O_ROUTE.dram)
      else $error("no hole yet access not claimed");

   addr_kept_a: assert property (
      I_HOST_ADDR_STROBE |=> O_ROUTE.addr == $past(I_HOST_REQ.addr))
      else $error("routed address was translated");

   gate_global_a: assert property (
      I_HOST_ADDR_STROBE && req_compat && !global_smm_ram_enable_reg
      |=> O_ROUTE.hub && !O_ROUTE.dram)
      else $error("smm window claimed without global enable");

   open_visible_a: assert property (
      I_HOST_ADDR_STROBE && req_compat && global_smm_ram_enable_reg
      && smm_open_reg && !smm_lockdown_reg && !I_HOST_REQ.smm && !smm_data_block_reg
      |=> O_ROUTE.dram)
      else $error("open window not visible");

   data_denied_a: assert property (
      I_HOST_ADDR_STROBE && req_compat && global_smm_ram_enable_reg
      && smm_data_block_reg && !I_HOST_REQ.code
      |=> O_ROUTE.hub)
      else $error("data reference reached closed smm ram");

   code_passes_a: assert property (
      I_HOST_ADDR_STROBE && req_compat && global_smm_ram_enable_reg
      && smm_data_block_reg && I_HOST_REQ.code && I_HOST_REQ.smm
      |=> O_ROUTE.dram)
      else $error("code reference blocked by closed control");

   block_scope_a: assert property (
      I_HOST_ADDR_STROBE && !req_compat && !req_hole |=> O_ROUTE.dram)
      else $error("access outside windows not claimed");

   lock_open_a: assert property (
      wr_smm && I_CFG_WDATA[smm_hole_pkg::LOCK_B] |=> smm_lockdown_reg && !smm_open_reg)
      else $error("lock did not clear open");

   lock_frozen_a: assert property (
      smm_lockdown_reg |=> $stable(global_smm_ram_enable_reg) && $stable(smm_open_reg))
      else $error("locked field changed");

   lock_sticky_a: assert property (
      smm_lockdown_reg |=> smm_lockdown_reg [*4])
      else $error("lock cleared without reset");

   smm_mapped_a: assert property (
      I_HOST_ADDR_STROBE && req_compat && global_smm_ram_enable_reg
      && I_HOST_REQ.smm && !smm_data_block_reg
      |=> O_ROUTE_VALID && O_ROUTE.dram && !O_ROUTE.hub)
      else $error("smm access not mapped to memory");

   ext_gated_a: assert property (
      !global_smm_ram_enable_reg ##1 !global_smm_ram_enable_reg |-> !O_EXT_SMM_ENABLE)
      else $error("extended smm enabled without global enable");

   base_fixed_a: assert property (
      I_CFG_RD && I_CFG_ADDR == smm_hole_pkg::SMM_OFS
      |=> O_CFG_RVALID && O_CFG_RDATA[2:0] == smm_hole_pkg::BASE_FIXED)
      else $error("base segment not fixed");

   rsvd_zero_a: assert property (
      I_CFG_RD && I_CFG_ADDR == smm_hole_pkg::HOLE_OFS |=> O_CFG_RDATA[6:0] == 7'h00)
      else $error("reserved hole bits not zero");

   rsvd_smm_a: assert property (
      I_CFG_RD && I_CFG_ADDR == smm_hole_pkg::SMM_OFS |=> !O_CFG_RDATA[7])
      else $error("reserved smm bit not zero");

   one_target_a: assert property (
      O_ROUTE_VALID |-> O_ROUTE.dram != O_ROUTE.hub)
      else $error("route not exactly one target");

   ext_follow_a: assert property (
      global_smm_ram_enable_reg |=> O_EXT_SMM_ENABLE)
      else $error("extended smm not enabled by global enable");

   locked_closed_a: assert property (
      I_HOST_ADDR_STROBE && req_compat && global_smm_ram_enable_reg
      && smm_lockdown_reg && !I_HOST_REQ.smm
      |=> O_ROUTE.hub && !O_ROUTE.dram)
      else $error("locked window visible outside smm");

   rd_idle_a: assert property (
      !I_CFG_RD |=> !O_CFG_RVALID && O_CFG_RDATA == smm_hole_pkg::RD_NONE)
      else $error("read answer without read strobe");

   hole_cov_c: cover property (
      I_HOST_ADDR_STROBE && req_hole && gap_15m_enable_reg ##1 O_ROUTE.hub);

   open_cov_c: cover property (
      I_HOST_ADDR_STROBE && req_compat && smm_open_reg && !I_HOST_REQ.smm ##1 O_ROUTE.dram);

   lock_cov_c: cover property (
      wr_smm && I_CFG_WDATA[smm_hole_pkg::LOCK_B] ##1 smm_lockdown_reg);

   code_cov_c: cover property (
      I_HOST_ADDR_STROBE && req_compat && smm_data_block_reg && I_HOST_REQ.code
      ##1 O_ROUTE.dram);

   lock_block_c: cover property (
      smm_lockdown_reg && wr_smm ##1 smm_data_block_reg);

endmodule

// file: design/smm_route_decode.sv
// Combinational routing decision for one host request.
// Assumes controls come straight from the configuration registers.
module smm_route_decode (
   input  wire logic                   i_valid,
   input  smm_hole_pkg::host_req_s     i_req,
   input  smm_hole_pkg::ctrl_s         i_ctrl,
   output smm_hole_pkg::route_s        o_route
);

   logic in_hole;
   logic in_compat;
   logic smm_ok;
   logic open_ok;
   logic data_deny;

   // -------------------------------------------------------------
   // Range checks
   // -------------------------------------------------------------
   assign in_hole   = i_ctrl.hole_en && (i_req.addr >= smm_hole_pkg::HOLE_LO)
                      && (i_req.addr < smm_hole_pkg::HOLE_HI);
   assign in_compat = (i_req.addr >= smm_hole_pkg::COMPAT_LO)
                      && (i_req.addr < smm_hole_pkg::COMPAT_HI);

   // Visibility of the compatible window
   assign open_ok   = i_ctrl.gen && i_ctrl.open && !i_ctrl.lock;
   assign data_deny = i_ctrl.gen && i_ctrl.block && !i_req.code;
   assign smm_ok    = i_ctrl.gen && (i_req.smm || open_ok) && !data_deny;

   // Claim or forward; address passes untouched
   always_comb begin
      o_route.addr = i_req.addr;
      if (!i_valid) begin
         o_route.dram = 1'b0;
      end else if (in_compat) begin
         o_route.dram = smm_ok;
      end else begin
         o_route.dram = !in_hole;
      end
      o_route.hub = i_valid && !o_route.dram;
   end

endmodule

// file: tb/host_master_model.sv
// Host bus master model: issues one request per command at the address strobe.
// Assumes commands from the bench arrive by non-blocking assignment on the clock edge.
module host_master_model (
   input  wire logic               i_clk,
   input  wire logic               i_go,
   input  smm_hole_pkg::host_req_s i_cmd,
   output logic                    o_strobe,
   output smm_hole_pkg::host_req_s o_req
);
   timeunit 1ns;
   timeprecision 100ps;

   // -------------------------------------------------------------
   // Request launch
   // -------------------------------------------------------------
   // One-cycle strobe; an idle bus shows the inverse of the last command
   always @(posedge i_clk) begin
      o_strobe <= i_go;
      o_req    <= i_go ? i_cmd : ~i_cmd;
   end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the SMM RAM control and 15 MB hole decode.
// Assumes the design answers config reads and host requests one cycle after taking them.
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   // -------------------------------------------------------------
   // Signals and shadow state
   // -------------------------------------------------------------
   logic                    clk = 1'b0;
   logic                    rst = 1'b1;
   logic                    cfg_wr = 1'b0;
   logic                    cfg_rd = 1'b0;
   logic [7:0]              cfg_addr = 8'h00;
   logic [7:0]              cfg_wdata = 8'h00;
   logic                    go = 1'b0;
   smm_hole_pkg::host_req_s cmd = '0;
   logic                    strobe;
   smm_hole_pkg::host_req_s req;
   logic [7:0]              rdata;
   logic                    rvalid;
   logic                    route_valid;
   smm_hole_pkg::route_s    route;
   logic                    lock;
   logic                    ext;
   int                      n_mismatch = 0;
   int                      cmp_count = 0;
   int                      cycles = 0;
   logic                    s_hole = 1'b0;
   logic                    s_open = 1'b0;
   logic                    s_block = 1'b0;
   logic                    s_lock = 1'b0;
   logic                    s_gen = 1'b0;

   // Clock at 40 MHz
   initial begin
      forever #12.5 clk = ~clk;
   end

   // -------------------------------------------------------------
   // Instances
   // -------------------------------------------------------------
   host_master_model u_host_master_model (
      .i_clk    (clk),
      .i_go     (go),
      .i_cmd    (cmd),
      .o_strobe (strobe),
      .o_req    (req)
   );

   smm_ram_and_dram_hole_decode u_smm_ram_and_dram_hole_decode (
      .I_CLK              (clk),
      .I_RST              (rst),
      .I_CFG_WR           (cfg_wr),
      .I_CFG_RD           (cfg_rd),
      .I_CFG_ADDR         (cfg_addr),
      .I_CFG_WDATA        (cfg_wdata),
      .I_HOST_ADDR_STROBE (strobe),
      .I_HOST_REQ         (req),
      .O_CFG_RDATA        (rdata),
      .O_CFG_RVALID       (rvalid),
      .O_ROUTE_VALID      (route_valid),
      .O_ROUTE            (route),
      .O_SMM_LOCK         (lock),
      .O_EXT_SMM_ENABLE   (ext)
   );

   // -------------------------------------------------------------
   // Verdict, compares and expectations
   // -------------------------------------------------------------
   task automatic close_out();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_mismatch = n_mismatch + 1;
         close_out();
      end
   end

   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         n_mismatch = n_mismatch + 1;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic chk_rt(input string nm, input smm_hole_pkg::route_s e,
                         input smm_hole_pkg::route_s g);
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         n_mismatch = n_mismatch + 1;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask

   function automatic logic [7:0] smm_val();
      return {1'b0, s_open, s_block, s_lock, s_gen, smm_hole_pkg::BASE_FIXED};
   endfunction

   // Routing expected from the shadow controls
   function automatic smm_hole_pkg::route_s exp_route(input logic [31:0] a, input logic s,
                                                      input logic c);
      smm_hole_pkg::route_s r;
      r.addr = a;
      r.dram = 1'b1;
      if (s_hole && a >= smm_hole_pkg::HOLE_LO && a < smm_hole_pkg::HOLE_HI)
         r.dram = 1'b0;
      if (a >= smm_hole_pkg::COMPAT_LO && a < smm_hole_pkg::COMPAT_HI)
         r.dram = s_gen && (s || (s_open && !s_lock)) && !(s_block && !c);
      r.hub = ~r.dram;
      return r;
   endfunction

   // -------------------------------------------------------------
   // Bus tasks
   // -------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      cfg_wr    <= 1'b1;
      cfg_addr  <= a;
      cfg_wdata <= d;
      @(posedge clk);
      cfg_wr <= 1'b0;
      if (a == smm_hole_pkg::HOLE_OFS) s_hole = d[7];
      if (a == smm_hole_pkg::SMM_OFS) begin
         s_block = d[5];
         if (!s_lock) begin
            s_gen  = d[3];
            s_lock = d[4];
            s_open = d[6] & ~d[4];
         end
      end
   endtask

   task automatic rd(input logic [7:0] a);
      logic [7:0] e;
      e = (a == smm_hole_pkg::HOLE_OFS) ? {s_hole, 7'h00} :
          (a == smm_hole_pkg::SMM_OFS) ? smm_val() : 8'h00;
      @(posedge clk);
      cfg_rd   <= 1'b1;
      cfg_addr <= a;
      @(posedge clk);
      cfg_rd <= 1'b0;
      #1;
      chk8("cfg_rvalid", 8'h01, {7'h00, rvalid});
      chk8("cfg_rdata", e, rdata);
      chk8("lock_ext", {6'h00, s_lock, s_gen}, {6'h00, lock, ext});
      @(posedge clk);
      #1;
      chk8("cfg_rvalid_end", 8'h00, {7'h00, rvalid});
      chk8("cfg_rdata_end", 8'h00, rdata);
   endtask

   task automatic hr(input logic [31:0] a, input logic s, input logic c);
      @(posedge clk);
      go  <= 1'b1;
      cmd <= '{addr: a, smm: s, code: c};
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      #1;
      chk8("route_valid", 8'h01, {7'h00, route_valid});
      chk_rt("route", exp_route(a, s, c), route);
      @(posedge clk);
      #1;
      chk8("route_valid_end", 8'h00, {7'h00, route_valid});
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      {s_hole, s_open, s_block, s_lock, s_gen} = 5'h00;
   endtask

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      logic [7:0]  a;
      logic [7:0]  d;
      logic [31:0] ha;
      void'($urandom(32'he6e88a7d));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(smm_hole_pkg::HOLE_OFS);
      rd(smm_hole_pkg::SMM_OFS);
      rd(8'h98);
      hr(32'h000a0000, 1'b1, 1'b0);
      wr(smm_hole_pkg::SMM_OFS, 8'h4f);
      rd(smm_hole_pkg::SMM_OFS);
      hr(32'h000a0000, 1'b0, 1'b0);
      hr(32'h000bffff, 1'b0, 1'b1);
      hr(32'h000c0000, 1'b0, 1'b0);
      hr(32'h0009ffff, 1'b1, 1'b0);
      wr(smm_hole_pkg::SMM_OFS, 8'h40);
      hr(32'h000a0000, 1'b0, 1'b0);
      wr(smm_hole_pkg::SMM_OFS, 8'h28);
      hr(32'h000a0000, 1'b1, 1'b0);
      hr(32'h000b0000, 1'b1, 1'b1);
      hr(32'h00f00000, 1'b1, 1'b0);
      wr(smm_hole_pkg::HOLE_OFS, 8'hff);
      rd(smm_hole_pkg::HOLE_OFS);
      hr(32'h00f00000, 1'b0, 1'b0);
      hr(32'h00ffffff, 1'b0, 1'b0);
      hr(32'h00efffff, 1'b0, 1'b0);
      hr(32'h01000000, 1'b0, 1'b0);
      wr(smm_hole_pkg::SMM_OFS, 8'h48);
      wr(smm_hole_pkg::SMM_OFS, 8'h08);
      wr(smm_hole_pkg::SMM_OFS, 8'h18);
      wr(smm_hole_pkg::SMM_OFS, 8'h47);
      rd(smm_hole_pkg::SMM_OFS);
      hr(32'h000a0000, 1'b0, 1'b1);
      wr(smm_hole_pkg::SMM_OFS, 8'h00);
      rd(smm_hole_pkg::SMM_OFS);
      do_reset();
      rd(smm_hole_pkg::SMM_OFS);
      // Random mix of config traffic and host requests
      repeat (300) begin
         if ($urandom % 2 == 0) begin
            a = ($urandom % 2) ? smm_hole_pkg::HOLE_OFS : smm_hole_pkg::SMM_OFS;
            if ($urandom % 8 == 0) a = 8'($urandom);
            d = 8'($urandom);
            d[4] = ($urandom % 40 == 0) && !s_open;
            if (d[4]) d[6] = 1'b0;
            if (d[6]) d[5] = 1'b0;
            if ($urandom % 2) wr(a, d);
            else rd(a);
         end else begin
            case ($urandom % 3)
               0: ha = 32'h0009fff0 + ($urandom % 32'h00020020);
               1: ha = 32'h00effff0 + ($urandom % 32'h00100020);
               default: ha = $urandom;
            endcase
            hr(ha, 1'($urandom), 1'($urandom));
         end
      end
      close_out();
   end
endmodule
